// >>> verilog/hmp_defines.svh
// constants for the host memory port: offsets, fields, resets, boot
`ifndef HMP_DEFINES_SVH
`define HMP_DEFINES_SVH
`define HMP_ADDR_REG_OFS 14'h3fe0
`define HMP_PAGE_REG_OFS 14'h3fe7
`define HMP_MMR_BASE 14'h3fe0
`define HMP_LATCH_PAGE_BIT 15
`define HMP_SPACE_BIT 14
`define HMP_SHORT_READ_BIT 14
`define HMP_ADDR_RST 14'h0000
`define HMP_PAGE_RST 16'h0000
`define HMP_BOOT_STRAP 3'h5
`define HMP_BOOT_ADDR 14'h0000
`endif

// >>> verilog/hmp_pkg.sv
// types for the host memory port
`default_nettype none
package hmp_pkg;
  typedef enum logic [1:0] {
    HMP_IDLE = 2'b00,
    HMP_SYNC = 2'b01,
    HMP_ACCESS = 2'b10,
    HMP_WAIT = 2'b11
  } hmp_state_t;
endpackage
`default_nettype wire

// >>> verilog/hmp_sync.sv
// two flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module hmp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_d;
  // next values for the two stages
  always_comb
  begin
    meta_d = srst ? RST : din;
    out_d = srst ? RST : meta_q;
  end
  // register both stages
  always_ff @(posedge clk)
  begin
    meta_q <= meta_d;
    dout <= out_d;
  end
endmodule
`default_nettype wire

// >>> verilog/hmp_port.sv
// host memory port: host strobes to on-chip program and data memory
// How it works
// - page latch takes bus bits seven to zero
// - address latch takes fourteen bits plus space
// - host never writes control register area
// - shared 16-bit bus, 24-bit program words
// - strobes synchronised, core keeps running
// - address increments after each data access or full program word
// - latch strobe falling edge captures address
// - one cycle sync, one cycle access
// - host cannot read latched address or page
// - core writes address register in data space
// - page register bit fourteen picks read timing
// - strap pattern five selects host boot
// - boot stalls until program word zero written
// - strap pins sampled while reset held
// - accesses still serviced while core idles
`timescale 1ns/1ps
`default_nettype none
`include "hmp_defines.svh"
module hmp_port (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic HOST_SELECT_N,
  input wire logic ADDRESS_LATCH_STROBE,
  input wire logic HOST_READ_STROBE_N,
  input wire logic HOST_WRITE_STROBE_N,
  input wire logic [15:0] HOST_ADDR_DATA_BUS_IN,
  output logic [15:0] HOST_ADDR_DATA_BUS_OUT,
  output logic HOST_ADDR_DATA_BUS_OE,
  output logic HOST_ACKNOWLEDGE_N,
  input wire logic [2:0] FLAG_PINS_MODE,
  input wire logic CORE_IDLE,
  input wire logic CORE_REG_WE,
  input wire logic [13:0] CORE_REG_ADDR,
  input wire logic [15:0] CORE_REG_WDATA,
  output logic [15:0] CORE_REG_RDATA,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_PROGRAM_SPACE,
  output logic [13:0] MEM_ADDR,
  output logic [23:0] MEM_WDATA,
  input wire logic [23:0] MEM_RDATA,
  output logic CORE_RUN,
  output logic SHORT_READ_ALT
);
  logic [3:0] strb_raw;
  logic [3:0] strb_s;
  logic [15:0] bus_s;
  logic sel, ale, rd, wr;
  // every host pin passes two flops first
  assign strb_raw = {~HOST_SELECT_N, ADDRESS_LATCH_STROBE,
                     ~HOST_READ_STROBE_N, ~HOST_WRITE_STROBE_N};
  hmp_sync #(.W(4), .RST(4'h0)) u_strb (
    .clk(SYS_CLK),
    .srst(SRST),
    .din(strb_raw),
    .dout(strb_s)
  );
  hmp_sync #(.W(16), .RST(16'h0000)) u_bus (
    .clk(SYS_CLK),
    .srst(SRST),
    .din(HOST_ADDR_DATA_BUS_IN),
    .dout(bus_s)
  );
  assign sel = strb_s[3];
  assign ale = strb_s[2];
  assign rd = strb_s[1];
  assign wr = strb_s[0];

  hmp_pkg::hmp_state_t st_q, st_d;
  logic ale_q, ale_d;
  logic [13:0] addr_q, addr_d;
  logic space_q, space_d;
  logic [15:0] page_q, page_d;
  logic [15:0] hi_q, hi_d;
  logic half_q, half_d;
  logic is_wr_q, is_wr_d;
  logic boot_q, boot_d;
  logic [2:0] strap_m_q, strap_m_d, strap_s_q, strap_s_d;
  logic psp_d, sra_d;
  logic [13:0] maddr_d;
  logic run_q, run_d;
  logic ack_n_d;
  logic req_d, we_d;
  logic [23:0] wdat_d;
  logic [15:0] out_d;
  logic oe_d;
  logic [15:0] rdat_d;
  logic do_acc, protect;

  // address or page latch, strobes, access sequencing and boot
  always_comb
  begin
    st_d = st_q;
    ale_d = ale;
    addr_d = addr_q;
    space_d = space_q;
    page_d = page_q;
    hi_d = hi_q;
    half_d = half_q;
    is_wr_d = is_wr_q;
    boot_d = boot_q;
    strap_m_d = FLAG_PINS_MODE; // straps are pins: two flops first
    strap_s_d = strap_m_q;
    run_d = run_q;
    req_d = 1'b0;
    we_d = 1'b0;
    wdat_d = MEM_WDATA;
    out_d = HOST_ADDR_DATA_BUS_OUT;
    oe_d = sel & rd; // drives only during a read strobe
    do_acc = 1'b0;
    // control register area is fenced off for host writes
    protect = (addr_q >= `HMP_MMR_BASE) && !space_q;
    if (SRST)
      boot_d = (strap_s_q == `HMP_BOOT_STRAP);
    else
      run_d = !boot_q; // boot holds the core off
    // falling edge of latch strobe while selected
    if (sel && ale_q && !ale && st_q == hmp_pkg::HMP_IDLE)
    begin
      if (bus_s[`HMP_LATCH_PAGE_BIT])
        page_d = {page_q[15:8], bus_s[7:0]};
      else
      begin
        addr_d = bus_s[13:0];
        space_d = bus_s[`HMP_SPACE_BIT];
        half_d = 1'b0;
      end
    end
    // core side writes to the two mapped registers
    if (CORE_REG_WE && CORE_REG_ADDR == `HMP_ADDR_REG_OFS)
    begin
      addr_d = CORE_REG_WDATA[13:0];
      space_d = CORE_REG_WDATA[`HMP_SPACE_BIT];
      half_d = 1'b0;
    end
    if (CORE_REG_WE && CORE_REG_ADDR == `HMP_PAGE_REG_OFS)
      page_d = CORE_REG_WDATA;
    case (st_q)
      hmp_pkg::HMP_IDLE:
        if (sel && (rd || wr))
        begin
          is_wr_d = wr;
          st_d = hmp_pkg::HMP_SYNC; // sync cycle
        end
      hmp_pkg::HMP_SYNC:
        st_d = hmp_pkg::HMP_ACCESS;
      hmp_pkg::HMP_ACCESS:
      begin
        do_acc = 1'b1; // one access cycle, also while idle
        st_d = hmp_pkg::HMP_WAIT;
      end
      hmp_pkg::HMP_WAIT:
        if (!(sel && (rd || wr)))
          st_d = hmp_pkg::HMP_IDLE;
      default:
        st_d = hmp_pkg::HMP_IDLE;
    endcase
    // program words pass as two bus words, high 16 then low 8
    if (do_acc)
    begin
      if (space_q && !half_q)
      begin
        half_d = 1'b1;
        if (is_wr_q)
          hi_d = bus_s;
        else
          out_d = MEM_RDATA[23:8];
        if (!is_wr_q)
          req_d = 1'b1;
      end
      else
      begin
        half_d = 1'b0;
        req_d = !(is_wr_q && protect);
        we_d = is_wr_q && !protect;
        if (space_q)
          wdat_d = {hi_q, bus_s[7:0]};
        else
          wdat_d = {8'h00, bus_s};
        if (!is_wr_q)
          out_d = space_q ? {8'h00, MEM_RDATA[7:0]} : MEM_RDATA[15:0];
        addr_d = addr_q + 14'h0001;
        if (boot_q && is_wr_q && space_q && addr_q == `HMP_BOOT_ADDR)
          boot_d = 1'b0;
      end
    end
    // ack low only when port can take a strobe
    ack_n_d = !(st_d == hmp_pkg::HMP_IDLE);
    // core readback; host path never returns these
    rdat_d = 16'h0000;
    if (CORE_REG_ADDR == `HMP_ADDR_REG_OFS)
      rdat_d = {1'b0, space_q, addr_q};
    else if (CORE_REG_ADDR == `HMP_PAGE_REG_OFS)
      rdat_d = page_q;
    // memory side address and timing select from the latched state
    psp_d = space_q;
    maddr_d = addr_q;
    sra_d = page_q[`HMP_SHORT_READ_BIT];
    if (SRST)
    begin
      st_d = hmp_pkg::HMP_IDLE;
      ale_d = 1'b0;
      addr_d = `HMP_ADDR_RST;
      space_d = 1'b0;
      page_d = `HMP_PAGE_RST;
      half_d = 1'b0;
      run_d = 1'b0;
      req_d = 1'b0;
      we_d = 1'b0;
      oe_d = 1'b0;
      out_d = 16'h0000;
      ack_n_d = 1'b1;
      wdat_d = 24'h000000;
      hi_d = 16'h0000;
      psp_d = 1'b0;
      maddr_d = 14'h0000;
      sra_d = 1'b0;
      rdat_d = 16'h0000;
      is_wr_d = 1'b0;
    end
  end

  // register all state and outputs
  always_ff @(posedge SYS_CLK)
  begin
    st_q <= st_d;
    ale_q <= ale_d;
    addr_q <= addr_d;
    space_q <= space_d;
    page_q <= page_d;
    hi_q <= hi_d;
    half_q <= half_d;
    is_wr_q <= is_wr_d;
    boot_q <= boot_d;
    strap_m_q <= strap_m_d;
    strap_s_q <= strap_s_d;
    run_q <= run_d;
    HOST_ACKNOWLEDGE_N <= ack_n_d;
    HOST_ADDR_DATA_BUS_OUT <= out_d;
    HOST_ADDR_DATA_BUS_OE <= oe_d;
    MEM_REQ <= req_d;
    MEM_WE <= we_d;
    MEM_PROGRAM_SPACE <= psp_d;
    MEM_ADDR <= maddr_d;
    MEM_WDATA <= wdat_d;
    CORE_REG_RDATA <= rdat_d;
    CORE_RUN <= run_d;
    SHORT_READ_ALT <= sra_d;
  end
endmodule
`default_nettype wire

// >>> verif/hmp_port_monitor.sv
// checker of the host memory port timing
`timescale 1ns/1ps
`default_nettype none
module hmp_port_monitor (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic HOST_SELECT_N,
  input wire logic HOST_READ_STROBE_N,
  input wire logic HOST_WRITE_STROBE_N,
  input wire logic HOST_ACKNOWLEDGE_N,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic MEM_PROGRAM_SPACE,
  input wire logic [13:0] MEM_ADDR
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // memory strobes tied to the host strobes behind them, plus acknowledge and control area checks
  a_we_req: assert property (MEM_WE |-> MEM_REQ)
    else $error("write alone");
  a_req_one: assert property (MEM_REQ |=> !MEM_REQ)
    else $error("long request");
  a_req_src: assert property (
    MEM_REQ |-> !$past(HOST_SELECT_N, 3)) else $error("bad request");
  a_we_src: assert property (
    MEM_WE |-> !$past(HOST_WRITE_STROBE_N, 3)) else $error("bad write");
  a_rd_lat: assert property ($fell(HOST_READ_STROBE_N) &&
    !HOST_SELECT_N && !HOST_ACKNOWLEDGE_N |-> ##[4:6] MEM_REQ)
    else $error("slow read");
  a_ack_busy: assert property (MEM_REQ |-> HOST_ACKNOWLEDGE_N)
    else $error("ready while busy");
  a_ack_free: assert property ((!HOST_ACKNOWLEDGE_N &&
    HOST_READ_STROBE_N && HOST_WRITE_STROBE_N) [*3] |=> !HOST_ACKNOWLEDGE_N)
    else $error("busy while idle");
  a_no_ctrl: assert property (MEM_WE && !MEM_PROGRAM_SPACE |->
    MEM_ADDR < 14'h3fe0) else $error("control area written");
endmodule
bind hmp_port hmp_port_monitor u_mon (.SYS_CLK, .SRST, .HOST_SELECT_N,
  .HOST_READ_STROBE_N, .HOST_WRITE_STROBE_N, .HOST_ACKNOWLEDGE_N,
  .MEM_REQ, .MEM_WE, .MEM_PROGRAM_SPACE, .MEM_ADDR);
`default_nettype wire

// >>> verif/hmp_host_model.sv
// host processor model on the multiplexed port
`timescale 1ns/1ps
`default_nettype none
module hmp_host_model (
  input wire logic clk,
  input wire logic ack_n,
  input wire logic [15:0] din,
  output logic sel_n,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [15:0] dout
);
  int i;
  initial {sel_n, ale, rd_n, wr_n, dout} = 20'hb0000;
  // bounded wait for an acknowledge level
  task wait_ack(input logic v);
    for (i = 0; i < 40 && ack_n !== v; i++) @(negedge clk);
  endtask
  // address or page latch, driven only while acknowledged
  task latch(input logic [15:0] v);
    @(negedge clk);
    wait_ack(1'b0);
    sel_n = 1'b0;
    ale = 1'b1;
    dout = v;
    @(negedge clk);
    ale = 1'b0;
    repeat (3) @(negedge clk);
    sel_n = 1'b1;
    dout = ~v;
    repeat (3) @(negedge clk);
  endtask
  // one read or write, held until the port has answered
  task xfer(input logic wr, input logic [15:0] w, output logic [15:0] r);
    @(negedge clk);
    wait_ack(1'b0);
    sel_n = 1'b0;
    rd_n = wr;
    wr_n = !wr;
    dout = w;
    @(negedge clk);
    wait_ack(1'b1);
    repeat (3) @(negedge clk);
    r = din;
    {sel_n, rd_n, wr_n} = 3'h7;
    dout = ~w;
  endtask
endmodule
`default_nettype wire

// >>> verif/test_host_memory_dma_port.sv
// self-checking bench for the host memory port
`timescale 1ns/1ps
`default_nettype none
module test_host_memory_dma_port;
  logic clk = 1'b0, srst = 1'b1, idle = 1'b0, rwe = 1'b0, wseen = 1'b0;
  logic [2:0] mode = 3'h5;
  logic [13:0] radr = 14'h0, maddr;
  logic [15:0] rwd = 16'h0, hout, bout, r, crd;
  logic sel_n, ale, rd_n, wr_n, oe, ack_n, req, we, psp, run, sra;
  logic [23:0] mwd, la, lwd;
  wire logic [15:0] bus = oe ? bout : hout;
  wire logic [23:0] mrd = {10'h2a5, maddr};
  int num_errors = 0, check_count = 0;
  always #2.5 clk = ~clk;
  // note where each memory access went
  always @(posedge clk)
  begin
    if (req) la <= {10'h0, maddr};
    if (req) lwd <= mwd;
    if (we) wseen <= 1'b1;
  end
  hmp_port DUT (.SYS_CLK(clk), .SRST(srst), .HOST_SELECT_N(sel_n),
    .ADDRESS_LATCH_STROBE(ale), .HOST_READ_STROBE_N(rd_n),
    .HOST_WRITE_STROBE_N(wr_n), .HOST_ADDR_DATA_BUS_IN(bus),
    .HOST_ADDR_DATA_BUS_OUT(bout), .HOST_ADDR_DATA_BUS_OE(oe),
    .HOST_ACKNOWLEDGE_N(ack_n), .FLAG_PINS_MODE(mode), .CORE_IDLE(idle),
    .CORE_REG_WE(rwe), .CORE_REG_ADDR(radr), .CORE_REG_WDATA(rwd),
    .CORE_REG_RDATA(crd), .MEM_REQ(req), .MEM_WE(we),
    .MEM_PROGRAM_SPACE(psp), .MEM_ADDR(maddr), .MEM_WDATA(mwd),
    .MEM_RDATA(mrd), .CORE_RUN(run), .SHORT_READ_ALT(sra));
  hmp_host_model h (.clk, .ack_n, .din(bus), .sel_n, .ale, .rd_n, .wr_n,
    .dout(hout));
  // compare and count
  task check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // reset with the given straps
  task do_reset(input logic [2:0] m);
    @(negedge clk);
    mode = m;
    srst = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // core write to a mapped register
  task core_wr(input logic [13:0] a, input logic [15:0] d);
    @(negedge clk);
    {rwe, radr, rwd} = {1'b1, a, d};
    @(negedge clk);
    rwe = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // data reads in a row while the core idles
  task t_reads;
    idle = 1'b1;
    h.latch(16'h0100);
    h.xfer(1'b0, 16'h0, r);
    check({8'h0, r}, 24'h4100);
    check(la, 24'h100);
    h.xfer(1'b0, 16'h0, r);
    check(la, 24'h101);
    check({8'h0, r}, 24'h4101);
    idle = 1'b0;
  endtask
  // write into the control area is dropped, pointer still moves
  task t_guard;
    h.latch(16'h3fe0);
    wseen = 1'b0;
    h.xfer(1'b1, 16'h1234, r);
    check({23'h0, wseen}, 24'h0);
    h.xfer(1'b0, 16'h0, r);
    check(la, 24'h3fe1);
  endtask
  // core sets the pointer and read timing, host latches a page
  task t_core;
    core_wr(14'h3fe0, 16'h0200);
    check({8'h0, crd}, 24'h0200);
    h.xfer(1'b1, 16'hbeef, r);
    check(la, 24'h200);
    check(lwd, 24'hbeef);
    core_wr(14'h3fe7, 16'h4000);
    check({23'h0, sra}, 24'h1);
    h.latch(16'h8003);
    check({8'h0, crd}, 24'h4003);
    h.xfer(1'b0, 16'h0, r);
    check({23'h0, sra}, 24'h1);
    check({8'h0, r}, 24'h4201);
    check(la, 24'h201);
    core_wr(14'h3fe7, 16'h0);
    check({23'h0, sra}, 24'h0);
  endtask
  // host boot waits for program word zero
  task t_boot;
    check({23'h0, run}, 24'h0);
    h.latch(16'h4000);
    h.xfer(1'b1, 16'h1200, r);
    h.xfer(1'b1, 16'h0034, r);
    repeat (2) @(negedge clk);
    check({23'h0, run}, 24'h1);
    check(lwd, 24'h120034);
    h.latch(16'h4005);
    h.xfer(1'b0, 16'h0, r);
    check({8'h0, r}, 24'ha940);
    h.xfer(1'b0, 16'h0, r);
    check({8'h0, r}, 24'h0005);
    check(la, 24'h005);
    do_reset(3'h0);
    check({23'h0, run}, 24'h1);
  endtask
  task give_verdict;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    do_reset(3'h5);
    t_reads;
    t_guard;
    t_core;
    t_boot;
    give_verdict;
  end
  // hang guard: the run needs well under a thousand cycles
  initial
  begin
    #20000;
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
